// File: rtl/dmacb_pkg.sv
package dmacb_pkg;

  // Register offsets on the plain port.
  localparam logic [7:0] OFS_COUNT_HI  = 8'h2c;
  localparam logic [7:0] OFS_COUNT_LO  = 8'h2d;
  localparam logic [7:0] OFS_IO_ADDR   = 8'h2e;
  localparam logic [7:0] OFS_CONTROL   = 8'h2f;
  localparam logic [7:0] OFS_MEM_HI    = 8'h30;
  localparam logic [7:0] OFS_MEM_MID   = 8'h31;
  localparam logic [7:0] OFS_MEM_LO    = 8'h32;
  localparam logic [7:0] OFS_MODE      = 8'h33;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h35;

  // Control register field positions.
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_SIZE_BIT   = 6;
  localparam int CTL_DIR_BIT    = 5;
  localparam int CTL_REPEAT_BIT = 4;
  localparam int CTL_IRQEN_BIT  = 3;

  // Reset values.
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;
  localparam logic [7:0]  IO_ADDR_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [23:0] MEM_RESET      = 24'h000000;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;

  // Interrupt status bits.
  localparam int IRQ_END_BIT  = 0;
  localparam int IRQ_TRIG_BIT = 1;

  // Activation source codes.
  localparam logic [2:0] SRC_TIMER3   = 3'h3;
  localparam logic [2:0] SRC_SER_TX   = 3'h4;
  localparam logic [2:0] SRC_SER_RX   = 3'h5;
  localparam logic [2:0] SRC_PIN_EDGE = 3'h6;
  localparam logic [2:0] SRC_PIN_LOW  = 3'h7;

  typedef enum logic [1:0] {
    DMACB_IO,
    DMACB_REPEAT,
    DMACB_IDLE
  } dmacb_mode_e;

  typedef struct packed {
    logic        enable;
    logic        word_size;
    logic        decrement;
    logic        repeat_en;
    logic        irq_en;
    logic [2:0]  source;
  } dmacb_ctl_s;

  typedef struct packed {
    logic [3:0] timer_a;
    logic       ser_tx_empty;
    logic       ser_rx_full;
  } dmacb_req_s;

endpackage

// File: rtl/dmacb_trigger.sv
`timescale 1ns/1ps
module dmacb_trigger (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  // Selection and sources.
  input  wire logic [2:0]         source,
  input  wire dmacb_pkg::dmacb_req_s reqs,
  input  wire logic               request_pin_n,
  // Result.
  output logic                    trigger
);

  logic pin_q;
  logic pin_d;

  always_comb begin
    pin_d = request_pin_n;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= pin_d;
    end
  end

  always_comb begin
    trigger = 1'b0;
    unique case (source)
      3'h0, 3'h1, 3'h2, dmacb_pkg::SRC_TIMER3: begin
        trigger = reqs.timer_a[source[1:0]];
      end
      dmacb_pkg::SRC_SER_TX: trigger = reqs.ser_tx_empty;
      dmacb_pkg::SRC_SER_RX: trigger = reqs.ser_rx_full;
      dmacb_pkg::SRC_PIN_EDGE: trigger = pin_q & ~request_pin_n;
      dmacb_pkg::SRC_PIN_LOW: trigger = ~request_pin_n;
    endcase
  end

  property p_edge_once;
    @(posedge sys_clk) disable iff (!rstn)
      (source == dmacb_pkg::SRC_PIN_EDGE && trigger) |=> !trigger;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge trigger longer than one cycle");

  property p_low_level;
    @(posedge sys_clk) disable iff (!rstn)
      (source == dmacb_pkg::SRC_PIN_LOW) |-> (trigger == !request_pin_n);
  endproperty
  a_low_level: assert property (p_low_level) else $error("low level trigger wrong");

endmodule // dmacb_trigger

// File: rtl/dmacb_irq.sv
`timescale 1ns/1ps
module dmacb_irq (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Events and software access.
  input  wire logic [1:0] events,
  input  wire logic       clr_we,
  input  wire logic [1:0] clr_bits,
  input  wire logic       mask_we,
  input  wire logic [1:0] mask_bits,
  // State.
  output logic [1:0]      status,
  output logic [1:0]      mask,
  output logic            irq
);

  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;

  // A new event beats a clear in the same cycle.
  always_comb begin
    status_d = status_q;
    if (clr_we) begin
      status_d = status_q & ~clr_bits;
    end
    status_d = status_d | events;
    mask_d = mask_we ? mask_bits : mask_q;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= dmacb_pkg::IRQ_RESET;
      mask_q   <= dmacb_pkg::IRQ_RESET;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
    end
  end

  assign status = status_q;
  assign mask   = mask_q;
  assign irq    = |(status_q & mask_q);

endmodule // dmacb_irq

// File: rtl/dmacb_channel.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - In short address mode the fixed peripheral address of every transfer is 16'hff00 followed by the I/O address register.
// - In full address mode the I/O address register has no effect on the transfer address.
// - The activation select field picks timer 0..3 event A, serial transmit empty or receive full.
// - Select code six starts one transfer per falling edge of the request pin.
// - Select code seven requests transfers while the request pin stays low.
// - The interrupt enable bit passes or suppresses the transfer-end interrupt.
// - With the interrupt enabled, a request goes to the CPU while the enable bit reads zero.
// - Incrementing byte transfers add one to the memory address after each completed transfer outside idle mode.
module dmacb_channel (
  // Clock and reset.
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // Register port.
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_we,
  input  wire logic                   reg_re,
  output logic [7:0]                  reg_rdata,
  // Requesters.
  input  wire dmacb_pkg::dmacb_req_s  reqs,
  input  wire logic                   request_pin_n,
  // Transfer engine.
  output logic                        xfer_req,
  input  wire logic                   xfer_done,
  output logic [23:0]                 periph_addr,
  output logic [23:0]                 mem_addr,
  output logic                        word_size,
  output logic [1:0]                  chan_mode,
  // Interrupt.
  output logic                        irq
);

  dmacb_pkg::dmacb_ctl_s ctl_q;
  dmacb_pkg::dmacb_ctl_s ctl_d;
  logic [7:0]            io_addr_q;
  logic [7:0]            io_addr_d;
  logic [15:0]           count_q;
  logic [15:0]           count_d;
  logic [15:0]           init_q;
  logic [15:0]           init_d;
  logic [23:0]           mem_q;
  logic [23:0]           mem_d;
  logic                  full_q;
  logic                  full_d;
  logic [7:0]            rdata_q;
  logic [7:0]            rdata_d;
  logic                  pend_q;
  logic                  pend_d;
  logic                  trigger;
  logic [1:0]            status;
  logic [1:0]            mask;
  logic [1:0]            events;
  logic                  end_event;
  dmacb_pkg::dmacb_mode_e mode;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  dmacb_trigger u_trigger (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .source        (ctl_q.source),
    .reqs          (reqs),
    .request_pin_n (request_pin_n),
    .trigger       (trigger)
  );

  always_comb begin
    if (!ctl_q.repeat_en) begin
      mode = dmacb_pkg::DMACB_IO;
    end else if (!ctl_q.irq_en) begin
      mode = dmacb_pkg::DMACB_REPEAT;
    end else begin
      mode = dmacb_pkg::DMACB_IDLE;
    end
  end

  // Count reaches zero on the last completed transfer; repeat and idle reload instead unless full address mode is set.
  assign end_event = xfer_done && ctl_q.enable && count_q == 16'h0001 &&
                     (full_q || mode == dmacb_pkg::DMACB_IO);

  always_comb begin
    ctl_d     = ctl_q;
    io_addr_d = io_addr_q;
    count_d   = count_q;
    init_d    = init_q;
    mem_d     = mem_q;
    full_d    = full_q;
    pend_d    = pend_q;
    if (trigger && ctl_q.enable) begin
      pend_d = 1'b1;
    end
    if (xfer_done && pend_q) begin
      pend_d = trigger && ctl_q.enable;
      count_d = count_q - 16'h0001;
      if (count_q == 16'h0001 && !full_q && mode != dmacb_pkg::DMACB_IO) begin
        count_d = init_q;
      end
      if (mode != dmacb_pkg::DMACB_IDLE) begin
        if (ctl_q.decrement) begin
          mem_d = mem_q - (ctl_q.word_size ? 24'h000002 : 24'h000001);
        end else begin
          mem_d = mem_q + (ctl_q.word_size ? 24'h000002 : 24'h000001);
        end
      end
      if (end_event) begin
        ctl_d.enable = 1'b0;
        pend_d = 1'b0;
      end
    end
    if (reg_we) begin
      unique case (1'b1)
        hit(reg_addr, dmacb_pkg::OFS_CONTROL): ctl_d = dmacb_pkg::dmacb_ctl_s'(reg_wdata);
        hit(reg_addr, dmacb_pkg::OFS_IO_ADDR): io_addr_d = reg_wdata;
        hit(reg_addr, dmacb_pkg::OFS_COUNT_HI): begin
          count_d[15:8] = reg_wdata;
          init_d[15:8]  = reg_wdata;
        end
        hit(reg_addr, dmacb_pkg::OFS_COUNT_LO): begin
          count_d[7:0] = reg_wdata;
          init_d[7:0]  = reg_wdata;
        end
        hit(reg_addr, dmacb_pkg::OFS_MEM_HI): mem_d[23:16] = reg_wdata;
        hit(reg_addr, dmacb_pkg::OFS_MEM_MID): mem_d[15:8] = reg_wdata;
        hit(reg_addr, dmacb_pkg::OFS_MEM_LO): mem_d[7:0] = reg_wdata;
        hit(reg_addr, dmacb_pkg::OFS_MODE): full_d = reg_wdata[0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    if (reg_re) begin
      unique case (1'b1)
        hit(reg_addr, dmacb_pkg::OFS_CONTROL): rdata_d = 8'(ctl_q);
        hit(reg_addr, dmacb_pkg::OFS_IO_ADDR): rdata_d = io_addr_q;
        hit(reg_addr, dmacb_pkg::OFS_COUNT_HI): rdata_d = count_q[15:8];
        hit(reg_addr, dmacb_pkg::OFS_COUNT_LO): rdata_d = count_q[7:0];
        hit(reg_addr, dmacb_pkg::OFS_MEM_HI): rdata_d = mem_q[23:16];
        hit(reg_addr, dmacb_pkg::OFS_MEM_MID): rdata_d = mem_q[15:8];
        hit(reg_addr, dmacb_pkg::OFS_MEM_LO): rdata_d = mem_q[7:0];
        hit(reg_addr, dmacb_pkg::OFS_MODE): rdata_d = {7'h00, full_q};
        hit(reg_addr, dmacb_pkg::OFS_IRQ_STAT): rdata_d = {6'h00, status};
        hit(reg_addr, dmacb_pkg::OFS_IRQ_MASK): rdata_d = {6'h00, mask};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_q     <= dmacb_pkg::dmacb_ctl_s'(dmacb_pkg::CONTROL_RESET);
      io_addr_q <= dmacb_pkg::IO_ADDR_RESET;
      count_q   <= dmacb_pkg::COUNT_RESET;
      init_q    <= dmacb_pkg::COUNT_RESET;
      mem_q     <= dmacb_pkg::MEM_RESET;
      full_q    <= 1'b0;
      rdata_q   <= 8'h00;
      pend_q    <= 1'b0;
    end else begin
      ctl_q     <= ctl_d;
      io_addr_q <= io_addr_d;
      count_q   <= count_d;
      init_q    <= init_d;
      mem_q     <= mem_d;
      full_q    <= full_d;
      rdata_q   <= rdata_d;
      pend_q    <= pend_d;
    end
  end

  assign events[dmacb_pkg::IRQ_END_BIT]  = end_event && ctl_q.irq_en;
  assign events[dmacb_pkg::IRQ_TRIG_BIT] = trigger && ctl_q.enable;

  // Clear on write of one; the set wins over a clear in the same cycle.
  dmacb_irq u_irq (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .events    (events),
    .clr_we    (reg_we && hit(reg_addr, dmacb_pkg::OFS_IRQ_STAT)),
    .clr_bits  (reg_wdata[1:0]),
    .mask_we   (reg_we && hit(reg_addr, dmacb_pkg::OFS_IRQ_MASK)),
    .mask_bits (reg_wdata[1:0]),
    .status    (status),
    .mask      (mask),
    .irq       ()
  );

  assign irq = (ctl_q.irq_en && !ctl_q.enable) || |(status & mask);

  assign periph_addr = full_q ? mem_q : {16'hff00, io_addr_q};
  assign mem_addr    = mem_q;
  assign word_size   = ctl_q.word_size;
  assign chan_mode   = mode;
  assign xfer_req    = pend_q && ctl_q.enable;
  assign reg_rdata   = rdata_q;

  property p_irq_gate;
    @(posedge sys_clk) disable iff (!rstn)
      (!ctl_q.enable && mask == 2'h0) |-> (irq == ctl_q.irq_en);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

  property p_irq_on_end;
    @(posedge sys_clk) disable iff (!rstn)
      (end_event && ctl_q.irq_en && !reg_we) |=> irq;
  endproperty
  a_irq_on_end: assert property (p_irq_on_end) else $error("no interrupt after transfer end");

  property p_inc_byte;
    @(posedge sys_clk) disable iff (!rstn)
      (xfer_done && pend_q && !ctl_q.decrement && !ctl_q.word_size && mode != dmacb_pkg::DMACB_IDLE && !reg_we)
        |=> (mem_q == $past(mem_q) + 24'h000001);
  endproperty
  a_inc_byte: assert property (p_inc_byte) else $error("byte increment not one");

  property p_short_addr;
    @(posedge sys_clk) disable iff (!rstn)
      !full_q |-> (periph_addr[7:0] == io_addr_q);
  endproperty
  a_short_addr: assert property (p_short_addr) else $error("peripheral address not io register");

  property p_full_addr;
    @(posedge sys_clk) disable iff (!rstn)
      full_q |-> (periph_addr == mem_q);
  endproperty
  a_full_addr: assert property (p_full_addr) else $error("io register used in full mode");

  property p_mode;
    @(posedge sys_clk) disable iff (!rstn)
      (ctl_q.repeat_en && ctl_q.irq_en) |-> (chan_mode == 2'(dmacb_pkg::DMACB_IDLE));
  endproperty
  a_mode: assert property (p_mode) else $error("idle mode decode wrong");

  property p_source_sel;
    @(posedge sys_clk) disable iff (!rstn)
      (ctl_q.source == dmacb_pkg::SRC_SER_RX) |-> (trigger == reqs.ser_rx_full);
  endproperty
  a_source_sel: assert property (p_source_sel) else $error("source select wrong");

  property p_read_latency;
    @(posedge sys_clk) disable iff (!rstn)
      (reg_re && reg_addr == dmacb_pkg::OFS_IO_ADDR && !reg_we) |=> (reg_rdata == $past(io_addr_q));
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data late");

  // A served transfer, and the one that empties the count.
  sequence s_step;
    xfer_done && pend_q;
  endsequence

  sequence s_last_done;
    s_step ##0 (ctl_q.enable && count_q == 16'h0001);
  endsequence

  property p_accept;
    @(posedge sys_clk) disable iff (!rstn)
      (trigger && ctl_q.enable && !xfer_done) |=> pend_q;
  endproperty
  a_accept: assert property (p_accept) else $error("accepted trigger not pending");

  property p_end_irq;
    @(posedge sys_clk) disable iff (!rstn)
      (s_last_done ##0 ((full_q || mode == dmacb_pkg::DMACB_IO) && ctl_q.irq_en && !reg_we))
        |=> (!ctl_q.enable && irq);
  endproperty
  a_end_irq: assert property (p_end_irq) else $error("last transfer did not raise interrupt");

  property p_end_quiet;
    @(posedge sys_clk) disable iff (!rstn)
      (s_last_done ##0 ((full_q || mode == dmacb_pkg::DMACB_IO) && !ctl_q.irq_en && !reg_we))
        |=> (status[dmacb_pkg::IRQ_END_BIT] == $past(status[dmacb_pkg::IRQ_END_BIT]));
  endproperty
  a_end_quiet: assert property (p_end_quiet) else $error("suppressed end interrupt was set");

  property p_repeat_reload;
    @(posedge sys_clk) disable iff (!rstn)
      (s_last_done ##0 (!full_q && mode != dmacb_pkg::DMACB_IO && !reg_we))
        |=> (ctl_q.enable && count_q == $past(init_q));
  endproperty
  a_repeat_reload: assert property (p_repeat_reload) else $error("repeat count not reloaded");

  property p_idle_hold;
    @(posedge sys_clk) disable iff (!rstn)
      (s_step ##0 (mode == dmacb_pkg::DMACB_IDLE && !reg_we)) |=> $stable(mem_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle mode moved the address");

  property p_word_step;
    @(posedge sys_clk) disable iff (!rstn)
      (s_step ##0 (!ctl_q.decrement && ctl_q.word_size && mode != dmacb_pkg::DMACB_IDLE && !reg_we))
        |=> (mem_q == $past(mem_q) + 24'h000002);
  endproperty
  a_word_step: assert property (p_word_step) else $error("word increment not two");

endmodule // dmacb_channel

// File: verif/dmacb_far_model.sv
`timescale 1ns/1ps
module dmacb_far_model (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // Bench commands.
  input  wire logic [5:0]       drive_reqs,
  input  wire logic             drive_pin_n,
  input  wire logic             slow,
  // Channel side.
  output dmacb_pkg::dmacb_req_s reqs,
  output logic                  request_pin_n,
  input  wire logic             xfer_req,
  output logic                  xfer_done
);
  logic [2:0] wait_q;
  logic [2:0] wait_d;
  logic       done_q;
  logic       done_d;

  assign reqs          = drive_reqs;
  assign request_pin_n = drive_pin_n;
  assign xfer_done     = done_q;

  // The engine rests a few cycles after each answer, so a request that is still dropping is not served twice.
  always_comb begin
    wait_d = wait_q;
    done_d = 1'b0;
    if (wait_q != 3'h0) begin
      wait_d = wait_q - 3'h1;
      done_d = (wait_q == 3'h3);
    end else if (xfer_req) begin
      wait_d = slow ? 3'h7 : 3'h4;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 3'h0;
      done_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      done_q <= done_d;
    end
  end
endmodule // dmacb_far_model

// File: verif/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module testbench;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [7:0]  reg_rdata;
  logic [5:0]  request_pin = 6'h00;
  logic        pin_n = 1'b1;
  logic        slow = 1'b0;
  dmacb_pkg::dmacb_req_s reqs;
  logic        request_pin_n;
  logic        xfer_req;
  logic        xfer_done;
  logic [23:0] periph_addr;
  logic [23:0] mem_addr;
  logic        word_size;
  logic [1:0]  chan_mode;
  logic        irq;
  int          miscompares = 0;
  int          n_compared = 0;
  logic [7:0]  d;
  logic [7:0]  io;
  logic [23:0] m;
  int          seed;

  always #2.5 sys_clk = ~sys_clk;

  dmacb_channel uut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .reqs(reqs), .request_pin_n(request_pin_n),
    .xfer_req(xfer_req), .xfer_done(xfer_done), .periph_addr(periph_addr), .mem_addr(mem_addr),
    .word_size(word_size), .chan_mode(chan_mode), .irq(irq));

  dmacb_far_model far (.sys_clk(sys_clk), .rstn(rstn), .drive_reqs(request_pin), .drive_pin_n(pin_n), .slow(slow),
    .reqs(reqs), .request_pin_n(request_pin_n), .xfer_req(xfer_req), .xfer_done(xfer_done));

  function automatic logic [7:0] ctl(logic en, logic sz, logic dir, logic rep, logic ie, logic [2:0] src);
    return {en, sz, dir, rep, ie, src};
  endfunction

  // Requester line that a source code selects, in the order of the request struct.
  function automatic logic [5:0] sel_mask(int code);
    return (code < 4) ? (6'h04 << code) : ((code == 4) ? 6'h02 : 6'h01);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge sys_clk);
    reg_we <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask

  task automatic pulse_req(input logic [5:0] mask);
    @(posedge sys_clk);
    request_pin <= mask;
    slow <= 1'($urandom % 2);
    @(posedge sys_clk);
    request_pin <= 6'h00;
  endtask

  // Watches long enough for a slow engine answer to finish as well.
  task automatic see_req(input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 14; i++) begin
      @(negedge sys_clk);
      if (xfer_req === 1'b1) seen = 1'b1;
    end
    `CHK(seen, exp)
  endtask

  task automatic end_sim();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #300000;
    miscompares++;
    end_sim();
  end

  initial begin
    seed = $urandom(18);
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(dmacb_pkg::OFS_CONTROL, d);
    `CHK(d, 8'h00)
    rd(8'h10, d);
    `CHK(d, 8'h00)
    io = 8'($urandom);
    wr(dmacb_pkg::OFS_IO_ADDR, io);
    `CHK(periph_addr, {16'hff00, io})
    rd(dmacb_pkg::OFS_IO_ADDR, d);
    `CHK(d, io)
    wr(dmacb_pkg::OFS_MODE, 8'h01);
    wr(dmacb_pkg::OFS_IO_ADDR, ~io);
    `CHK(periph_addr, 24'h000000)
    wr(dmacb_pkg::OFS_MODE, 8'h00);
    wr(dmacb_pkg::OFS_COUNT_HI, 8'h01);
    wr(dmacb_pkg::OFS_COUNT_LO, 8'h00);
    for (int c = 0; c < 6; c++) begin
      wr(dmacb_pkg::OFS_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'(c)));
      @(posedge sys_clk);
      request_pin <= ~sel_mask(c);
      see_req(1'b0);
      pulse_req(sel_mask(c));
      see_req(1'b1);
    end
    @(posedge sys_clk);
    pin_n <= 1'b0;
    wr(dmacb_pkg::OFS_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, dmacb_pkg::SRC_PIN_EDGE));
    see_req(1'b0);
    @(posedge sys_clk);
    pin_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pin_n <= 1'b0;
    see_req(1'b1);
    see_req(1'b0);
    wr(dmacb_pkg::OFS_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, dmacb_pkg::SRC_PIN_LOW));
    see_req(1'b1);
    @(posedge sys_clk);
    pin_n <= 1'b1;
    repeat (14) @(posedge sys_clk);
    see_req(1'b0);
    m = 24'($urandom);
    wr(dmacb_pkg::OFS_MEM_HI, m[23:16]);
    wr(dmacb_pkg::OFS_MEM_MID, m[15:8]);
    wr(dmacb_pkg::OFS_MEM_LO, m[7:0]);
    wr(dmacb_pkg::OFS_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, dmacb_pkg::SRC_SER_RX));
    pulse_req(6'h01);
    repeat (14) @(negedge sys_clk);
    `CHK(mem_addr, m + 24'h1)
    wr(dmacb_pkg::OFS_COUNT_HI, 8'h00);
    wr(dmacb_pkg::OFS_COUNT_LO, 8'h01);
    wr(dmacb_pkg::OFS_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, dmacb_pkg::SRC_SER_RX));
    `CHK(irq, 1'b0)
    pulse_req(6'h01);
    repeat (14) @(negedge sys_clk);
    rd(dmacb_pkg::OFS_CONTROL, d);
    `CHK(d[7], 1'b0)
    `CHK(irq, 1'b1)
    rd(dmacb_pkg::OFS_IRQ_STAT, d);
    `CHK(d[0], 1'b1)
    wr(dmacb_pkg::OFS_CONTROL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, dmacb_pkg::SRC_SER_RX));
    `CHK(irq, 1'b0)
    wr(dmacb_pkg::OFS_IRQ_MASK, 8'h01);
    `CHK(irq, 1'b1)
    wr(dmacb_pkg::OFS_IRQ_STAT, 8'h03);
    `CHK(irq, 1'b0)
    for (int k = 0; k < 4; k++) begin
      wr(dmacb_pkg::OFS_CONTROL, ctl(1'b0, k[1], 1'b0, k[1], k[0], 3'h0));
      `CHK(word_size, k[1])
      `CHK(chan_mode, (!k[1]) ? 2'h0 : ((!k[0]) ? 2'h1 : 2'h2))
    end
    // Repeat mode with decrementing bytes reloads the count and keeps the channel on.
    wr(dmacb_pkg::OFS_COUNT_HI, 8'h00);
    wr(dmacb_pkg::OFS_COUNT_LO, 8'h02);
    wr(dmacb_pkg::OFS_CONTROL, ctl(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, dmacb_pkg::SRC_SER_RX));
    repeat (2) begin
      pulse_req(6'h01);
      repeat (14) @(negedge sys_clk);
    end
    rd(dmacb_pkg::OFS_CONTROL, d);
    `CHK(d[7], 1'b1)
    rd(dmacb_pkg::OFS_COUNT_LO, d);
    `CHK(d, 8'h02)
    `CHK(mem_addr, m)
    `CHK(irq, 1'b0)
    // Idle mode holds the address; word transfers in I/O mode step by two.
    wr(dmacb_pkg::OFS_CONTROL, ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, dmacb_pkg::SRC_SER_RX));
    pulse_req(6'h01);
    repeat (14) @(negedge sys_clk);
    `CHK(mem_addr, m)
    wr(dmacb_pkg::OFS_CONTROL, ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, dmacb_pkg::SRC_SER_RX));
    pulse_req(6'h01);
    repeat (14) @(negedge sys_clk);
    `CHK(mem_addr, m + 24'h2)
    `CHK(irq, 1'b0)
    rd(dmacb_pkg::OFS_CONTROL, d);
    `CHK(d[7], 1'b0)
    end_sim();
  end
endmodule // testbench
